/* src/dbs_map.svh */
// Constants for the data-side bus sideband unit
`ifndef DBS_MAP_SVH
`define DBS_MAP_SVH
`define DBS_SIZE_BYTE 2'h0
`define DBS_SIZE_HALF 2'h1
`define DBS_SIZE_WORD 2'h2
`define DBS_SIZE_RSVD 2'h3
`define DBS_VEC_LOW   32'h00000000
`define DBS_VEC_HIGH  32'hFFFF0000
`define DBS_MODE_RST  5'h00
`define DBS_ADDR_RST  32'h00000000
`endif

/* src/dbs_pkg.sv */
// Types shared by the data-side bus sideband unit
package dbs_pkg;
  // One data access as the pipeline asks for it
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [1:0]  size;
    logic        write;
    logic        lock;
    logic        seq;
    logic        more;
    logic        priv;
    logic [4:0]  mode;
  } dbs_req_t;
  // Debug halt state
  typedef enum logic {DBS_RUN, DBS_HALT} dbs_state_t;
endpackage : dbs_pkg

/* src/dbs_sideband.sv */
// Data-side memory interface and sideband control unit
`timescale 1ns/1ps
`include "dbs_map.svh"
module dbs_sideband import dbs_pkg::*; (
  // Clock, resets and wait state enable
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        core_reset_n,
  input  wire logic        wait_state_enable,
  // Pipeline side
  input  wire logic        acc_valid,
  input  wire dbs_req_t    acc_req,
  input  wire logic        spec_hint,
  input  wire logic [31:0] spec_addr,
  input  wire logic        fiq_mask,
  input  wire logic        irq_mask,
  input  wire logic        debug_exit,
  output logic [31:0]      load_data,
  output logic             load_valid,
  output logic             access_fault,
  output logic             debug_halted,
  output logic             fast_int_pend,
  output logic             normal_int_pend,
  output logic [31:0]      vector_base,
  output logic [31:0]      restart_addr,
  output logic             big_endian,
  output logic             pc_load_compat_off,
  // Configuration straps
  input  wire logic        cfg_byte_order_high,
  input  wire logic        cfg_vector_base_high,
  input  wire logic        cfg_pc_load_compat_off,
  // Data memory pins
  output logic [31:0]      data_addr_bus,
  output logic [31:0]      wdata,
  input  wire logic [31:0] rdata,
  output logic             data_request_n,
  output logic             data_dir_write,
  output logic [1:0]       data_access_size,
  output logic             data_bus_locked,
  output logic             data_burst_continues,
  output logic             data_sequential,
  output logic             data_speculative_n,
  output logic             data_privileged,
  output logic [4:0]       data_cpu_mode,
  input  wire logic        data_access_fault_in,
  input  wire logic        data_watch_halt_in,
  // Interrupt pins
  input  wire logic        fast_int_req_n,
  input  wire logic        normal_int_req_n,
  output logic             fast_int_masked,
  output logic             normal_int_masked
);

  // Registers
  logic        req_n_q, spec_n_q, dir_q, lock_q, more_q, seq_q, priv_q;
  logic [1:0]  size_q;
  logic [4:0]  mode_q;
  logic [31:0] addr_q, wdata_q, load_q;
  logic        load_v_q, fault_q, fmask_q, imask_q;
  logic        big_q, hivec_q, ltoff_q, in_rst_q;
  dbs_state_t  state_q, state_d;

  // Decode of what advances this cycle
  wire         adv      = wait_state_enable;
  wire         running  = (state_q == DBS_RUN);
  wire         issue    = adv & acc_valid & running;
  // Request wins over hint so both strobes never fall together
  wire         spec_go  = adv & spec_hint & running & ~issue;
  wire         in_data  = ~req_n_q;
  wire         rd_done  = adv & in_data & ~dir_q;
  wire         any_done = adv & (in_data | ~spec_n_q);

  // Reserved size code is never let onto the pins
  wire [1:0]   size_ok  = (acc_req.size == `DBS_SIZE_RSVD) ?
                          `DBS_SIZE_WORD : acc_req.size;

  // Write lanes: replicating narrow data suits both byte orders
  wire [31:0]  wd_byte  = {4{acc_req.wdata[7:0]}};
  wire [31:0]  wd_half  = {2{acc_req.wdata[15:0]}};
  wire [31:0]  wd_lane  = (size_ok == `DBS_SIZE_BYTE) ? wd_byte :
                          (size_ok == `DBS_SIZE_HALF) ? wd_half :
                          acc_req.wdata;

  // Read lane select follows the strapped byte order and the address offset of the access in flight
  wire [1:0]   off      = addr_q[1:0];
  wire [1:0]   lane_b   = big_q ? ~off : off;
  wire         lane_h   = big_q ? ~off[1] : off[1];
  wire [7:0]   rd_byte  = rdata[{lane_b, 3'h0} +: 8];
  wire [15:0]  rd_half  = rdata[{lane_h, 4'h0} +: 16];
  wire [31:0]  rd_val   = (size_q == `DBS_SIZE_BYTE) ? {24'h000000, rd_byte} :
                          (size_q == `DBS_SIZE_HALF) ? {16'h0000, rd_half} :
                          rdata;

  // Watchpoint sampled at the end of a request cycle
  wire         wpt_hit  = adv & in_data & data_watch_halt_in;

  // Interrupts are taken straight in; the source is already synchronous
  wire         fiq_ign  = fmask_q | ~running;
  wire         irq_ign  = imask_q | ~running;

  // Debug halt state machine
  always_comb begin
    state_d = state_q;
    case (state_q)
      DBS_RUN:  if (wpt_hit) state_d = DBS_HALT;
      DBS_HALT: if (debug_exit) state_d = DBS_RUN;
      default:  state_d = DBS_RUN;
    endcase
  end

  // Pin qualifiers, set at end of cycle for the next cycle
  always_ff @(posedge core_clk or negedge core_reset_n) begin
    if (!core_reset_n) begin
      req_n_q  <= 1'b1;
      spec_n_q <= 1'b1;
      dir_q    <= 1'b0;
      lock_q   <= 1'b0;
      more_q   <= 1'b0;
      seq_q    <= 1'b0;
      priv_q   <= 1'b1;
      size_q   <= `DBS_SIZE_WORD;
      mode_q   <= `DBS_MODE_RST;
      addr_q   <= `DBS_ADDR_RST;
      wdata_q  <= 32'h00000000;
    end else if (rst) begin
      req_n_q  <= 1'b1;
      spec_n_q <= 1'b1;
      dir_q    <= 1'b0;
      lock_q   <= 1'b0;
      more_q   <= 1'b0;
      seq_q    <= 1'b0;
      priv_q   <= 1'b1;
      size_q   <= `DBS_SIZE_WORD;
      mode_q   <= `DBS_MODE_RST;
      addr_q   <= `DBS_ADDR_RST;
      wdata_q  <= 32'h00000000;
    end else if (adv) begin
      req_n_q  <= ~issue;
      spec_n_q <= ~spec_go;
      if (issue) begin
        addr_q   <= acc_req.addr;
        dir_q    <= acc_req.write;
        size_q   <= size_ok;
        lock_q   <= acc_req.lock;
        more_q   <= acc_req.more;
        seq_q    <= acc_req.seq;
        priv_q   <= acc_req.priv;
        mode_q   <= acc_req.mode;
        if (acc_req.write) begin
          wdata_q <= wd_lane;
        end
      end else begin
        // Lock and burst only describe a real access
        lock_q <= 1'b0;
        more_q <= 1'b0;
        seq_q  <= 1'b0;
        if (spec_go) begin
          addr_q <= spec_addr;
          dir_q  <= 1'b0;
        end
      end
    end
  end

  // Completion of the access in flight, plus halt state
  always_ff @(posedge core_clk or negedge core_reset_n) begin
    if (!core_reset_n) begin
      load_q   <= 32'h00000000;
      load_v_q <= 1'b0;
      fault_q  <= 1'b0;
      state_q  <= DBS_RUN;
    end else if (rst) begin
      load_q   <= 32'h00000000;
      load_v_q <= 1'b0;
      fault_q  <= 1'b0;
      state_q  <= DBS_RUN;
    end else begin
      load_v_q <= rd_done & ~data_access_fault_in;
      // Speculative probes come back aborted, so flag them too
      fault_q  <= any_done & data_access_fault_in;
      if (rd_done) begin
        load_q <= rd_val;
      end
      state_q  <= state_d;
    end
  end

  // Interrupt mask outputs
  always_ff @(posedge core_clk or negedge core_reset_n) begin
    if (!core_reset_n) begin
      fmask_q <= 1'b1;
      imask_q <= 1'b1;
    end else if (rst) begin
      fmask_q <= 1'b1;
      imask_q <= 1'b1;
    end else if (adv) begin
      fmask_q <= fiq_mask;
      imask_q <= irq_mask;
    end
  end

  // Straps caught while held in reset; static in operation
  always_ff @(posedge core_clk) begin
    in_rst_q <= rst | ~core_reset_n;
    if (in_rst_q) begin
      big_q   <= cfg_byte_order_high;
      hivec_q <= cfg_vector_base_high;
      ltoff_q <= cfg_pc_load_compat_off;
    end
  end

  // Pin and pipeline outputs
  assign data_addr_bus        = addr_q;
  assign wdata                = wdata_q;
  assign data_request_n       = req_n_q;
  assign data_speculative_n   = spec_n_q;
  assign data_dir_write       = dir_q;
  assign data_access_size     = size_q;
  assign data_bus_locked      = lock_q;
  assign data_burst_continues = more_q;
  assign data_sequential      = seq_q;
  assign data_privileged      = priv_q;
  assign data_cpu_mode        = mode_q;
  assign load_data            = load_q;
  assign load_valid           = load_v_q;
  assign access_fault         = fault_q;
  assign debug_halted         = (state_q == DBS_HALT);
  assign fast_int_masked      = fiq_ign;
  assign normal_int_masked    = irq_ign;
  assign fast_int_pend        = ~fast_int_req_n & ~fiq_ign;
  assign normal_int_pend      = ~normal_int_req_n & ~irq_ign;
  assign big_endian           = big_q;
  assign pc_load_compat_off   = ltoff_q;
  // Restart address is the reset vector at the chosen base
  assign vector_base          = hivec_q ? `DBS_VEC_HIGH : `DBS_VEC_LOW;
  assign restart_addr         = vector_base;

  // Checks
  a_strobe_exclusive: assert property (@(posedge core_clk)
    disable iff (rst || !core_reset_n) !(!data_request_n && !data_speculative_n))
    else $error("request and speculative low together");

  a_request_issue: assert property (@(posedge core_clk)
    disable iff (rst || !core_reset_n)
    (wait_state_enable && acc_valid && !debug_halted) |=> !data_request_n)
    else $error("request strobe missed an access");

  a_size_legal: assert property (@(posedge core_clk)
    disable iff (rst || !core_reset_n) data_access_size != `DBS_SIZE_RSVD)
    else $error("reserved size code driven");

  a_dir_follows: assert property (@(posedge core_clk)
    disable iff (rst || !core_reset_n)
    (wait_state_enable && acc_valid && !debug_halted)
    |=> data_dir_write == $past(acc_req.write))
    else $error("direction does not match access");

  a_stall_holds: assert property (@(posedge core_clk)
    disable iff (rst || !core_reset_n)
    !wait_state_enable |=> $stable(data_addr_bus) && $stable(data_request_n))
    else $error("pins moved during wait state");

  a_lock_mode: assert property (@(posedge core_clk)
    disable iff (rst || !core_reset_n)
    (wait_state_enable && acc_valid && !debug_halted)
    |=> data_bus_locked == $past(acc_req.lock) && data_cpu_mode == $past(acc_req.mode))
    else $error("lock or mode not carried");

  a_watch_halt: assert property (@(posedge core_clk)
    disable iff (rst || !core_reset_n)
    (wait_state_enable && !data_request_n && data_watch_halt_in)
    |=> debug_halted && data_request_n)
    else $error("watchpoint did not halt");

  a_spec_fault: assert property (@(posedge core_clk)
    disable iff (rst || !core_reset_n)
    (wait_state_enable && !data_speculative_n && data_access_fault_in) |=> access_fault)
    else $error("abort not reported");

  a_fiq_ignored: assert property (@(posedge core_clk)
    disable iff (rst || !core_reset_n) fast_int_masked |-> !fast_int_pend)
    else $error("masked fast interrupt seen as pending");

  a_irq_ignored: assert property (@(posedge core_clk)
    disable iff (rst || !core_reset_n) normal_int_masked |-> !normal_int_pend)
    else $error("masked normal interrupt seen as pending");

  a_fiq_taken: assert property (@(posedge core_clk)
    disable iff (rst || !core_reset_n)
    (!fast_int_req_n && !fast_int_masked) |-> fast_int_pend)
    else $error("unmasked fast interrupt not seen");

  a_irq_taken: assert property (@(posedge core_clk)
    disable iff (rst || !core_reset_n)
    (!normal_int_req_n && !normal_int_masked) |-> normal_int_pend)
    else $error("unmasked normal interrupt not seen");

  a_halt_masks: assert property (@(posedge core_clk)
    disable iff (rst || !core_reset_n)
    debug_halted |-> fast_int_masked && normal_int_masked)
    else $error("interrupt not ignored while halted");

  a_halt_refuse: assert property (@(posedge core_clk)
    disable iff (rst || !core_reset_n)
    (wait_state_enable && debug_halted && acc_valid) |=> data_request_n)
    else $error("access issued while halted");

  // Straps only move under reset, so the outputs must track them
  a_vector_base: assert property (@(posedge core_clk)
    disable iff (rst || !core_reset_n)
    vector_base == (cfg_vector_base_high ? `DBS_VEC_HIGH : `DBS_VEC_LOW))
    else $error("vector base does not follow its strap");

  a_restart_vector: assert property (@(posedge core_clk)
    disable iff (rst || !core_reset_n)
    restart_addr == (cfg_vector_base_high ? `DBS_VEC_HIGH : `DBS_VEC_LOW))
    else $error("restart address not the fixed vector");

  a_byte_order: assert property (@(posedge core_clk)
    disable iff (rst || !core_reset_n)
    big_endian == cfg_byte_order_high)
    else $error("byte order does not follow its strap");

  a_ltpc_strap: assert property (@(posedge core_clk)
    disable iff (rst || !core_reset_n)
    pc_load_compat_off == cfg_pc_load_compat_off)
    else $error("load to pc setting does not follow its strap");

  a_spec_addr: assert property (@(posedge core_clk)
    disable iff (rst || !core_reset_n)
    (wait_state_enable && spec_hint && !acc_valid && !debug_halted)
    |=> !data_speculative_n && data_addr_bus == $past(spec_addr))
    else $error("speculative hint or address missing");

  a_idle_release: assert property (@(posedge core_clk)
    disable iff (rst || !core_reset_n)
    (wait_state_enable && !acc_valid) |=> data_request_n && !data_bus_locked)
    else $error("request or lock held without an access");

  a_seq_more: assert property (@(posedge core_clk)
    disable iff (rst || !core_reset_n)
    (wait_state_enable && acc_valid && !debug_halted)
    |=> data_sequential == $past(acc_req.seq) && data_burst_continues == $past(acc_req.more))
    else $error("sequential or burst flag not carried");

  a_priv_addr: assert property (@(posedge core_clk)
    disable iff (rst || !core_reset_n)
    (wait_state_enable && acc_valid && !debug_halted)
    |=> data_privileged == $past(acc_req.priv) && data_addr_bus == $past(acc_req.addr))
    else $error("privilege or address not carried");

  a_read_done: assert property (@(posedge core_clk)
    disable iff (rst || !core_reset_n)
    (wait_state_enable && !data_request_n && !data_dir_write && !data_access_fault_in)
    |=> load_valid)
    else $error("clean read not reported");

  a_fault_read: assert property (@(posedge core_clk)
    disable iff (rst || !core_reset_n)
    (wait_state_enable && !data_request_n && data_access_fault_in)
    |=> access_fault && !load_valid)
    else $error("aborted access not reported");

endmodule : dbs_sideband

/* tb/dbs_mem_model.sv */
// Data memory model answering the sideband unit's pins
`timescale 1ns/1ps
module dbs_mem_model (
  // Clock and pins from the unit
  input  wire logic        core_clk,
  input  wire logic [31:0] data_addr_bus,
  input  wire logic        data_request_n,
  input  wire logic        data_dir_write,
  input  wire logic        data_speculative_n,
  input  wire logic        data_privileged,
  // Answers back to the unit
  output logic [31:0]      rdata,
  output logic             data_access_fault_in
);
  logic [31:0] last_q = 32'h00000000;
  // Read cycle decode and a word pattern keyed on the word address
  wire         rd_cyc = !data_request_n && !data_dir_write;
  wire  [31:0] word_w = {data_addr_bus[31:2], 2'h0} ^ 32'h3C5A96E1;
  // Idle bus shows the inverse of the last word so a stale copy cannot pass
  assign rdata = rd_cyc ? word_w : ~last_q;
  // Hint alone starts no prefetch; every probe aborts; upper half is supervisor only
  assign data_access_fault_in = !data_speculative_n ||
    (!data_request_n && !data_privileged && data_addr_bus[31]);
  // Remember the last word put on the bus
  always_ff @(posedge core_clk) begin
    if (rd_cyc) begin
      last_q <= word_w;
    end
  end
endmodule : dbs_mem_model

/* tb/test_dbs_sideband.sv */
// Self-checking bench for the data-side bus sideband unit
`timescale 1ns/1ps
module test_dbs_sideband import dbs_pkg::*; ();
  // Stimulus, driven at the falling edge
  logic        core_clk, rst, core_reset_n, wait_state_enable, acc_valid, spec_hint;
  logic        fiq_mask, irq_mask, debug_exit, data_watch_halt_in;
  logic        fast_int_req_n, normal_int_req_n;
  logic        cfg_byte_order_high, cfg_vector_base_high, cfg_pc_load_compat_off;
  logic [31:0] spec_addr, a;
  dbs_req_t    acc_req;
  // Observed outputs
  logic [31:0] load_data, vector_base, restart_addr, data_addr_bus, wdata, rdata;
  logic        load_valid, access_fault, debug_halted, fast_int_pend, normal_int_pend;
  logic        big_endian, pc_load_compat_off, data_request_n, data_dir_write;
  logic        data_bus_locked, data_burst_continues, data_sequential, data_speculative_n;
  logic        data_privileged, data_access_fault_in, fast_int_masked, normal_int_masked;
  logic [1:0]  data_access_size;
  logic [4:0]  data_cpu_mode;
  int          n_mismatch = 0, cmp_count = 0, cyc = 0;

  dbs_sideband dbs_sideband_i (.core_clk, .rst, .core_reset_n, .wait_state_enable,
    .acc_valid, .acc_req, .spec_hint, .spec_addr, .fiq_mask, .irq_mask, .debug_exit,
    .load_data, .load_valid, .access_fault, .debug_halted, .fast_int_pend,
    .normal_int_pend, .vector_base, .restart_addr, .big_endian, .pc_load_compat_off,
    .cfg_byte_order_high, .cfg_vector_base_high, .cfg_pc_load_compat_off,
    .data_addr_bus, .wdata, .rdata, .data_request_n, .data_dir_write, .data_access_size,
    .data_bus_locked, .data_burst_continues, .data_sequential, .data_speculative_n,
    .data_privileged, .data_cpu_mode, .data_access_fault_in, .data_watch_halt_in,
    .fast_int_req_n, .normal_int_req_n, .fast_int_masked, .normal_int_masked);
  dbs_mem_model dbs_mem_model_i (.core_clk, .data_addr_bus, .data_request_n,
    .data_dir_write, .data_speculative_n, .data_privileged, .rdata, .data_access_fault_in);

  // Clock and a hang guard far above the expected run of some 50 cycles
  initial begin
    core_clk = 1'h0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 1000) begin
      n_mismatch++;
      conclude();
    end
  end

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : conclude

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // Lane the unit should return for a read, worked out from the model's pattern
  function automatic logic [31:0] lane(input logic [31:0] ad, input logic [1:0] sz,
                                       input logic be);
    logic [31:0] w;
    logic [1:0]  i;
    w = {ad[31:2], 2'h0} ^ 32'h3C5A96E1;
    i = be ? ~ad[1:0] : ad[1:0];
    if (sz == 2'h0) return {24'h000000, w[8*i +: 8]};
    if (sz == 2'h1) return {16'h0000, w[16*i[1] +: 16]};
    return w;
  endfunction : lane

  // Straps change only while reset is held
  task automatic do_reset(input logic be, input logic hv);
    cfg_byte_order_high = be;
    cfg_vector_base_high = hv;
    cfg_pc_load_compat_off = be;
    rst = 1'h1;
    repeat (5) @(negedge core_clk);
    chk("req_n", {data_request_n, data_speculative_n}, 2'h3);
    chk("size", data_access_size, 2'h2);
    chk("mode", data_cpu_mode, 5'h00);
    chk("masked", {fast_int_masked, normal_int_masked, debug_halted}, 3'h6);
    chk("vector", vector_base, hv ? 32'hFFFF0000 : 32'h00000000);
    chk("restart", restart_addr, hv ? 32'hFFFF0000 : 32'h00000000);
    chk("order", big_endian, be);
    chk("ltpc", pc_load_compat_off, be);
    rst = 1'h0;
    @(negedge core_clk);
    $display("test reset done");
  endtask : do_reset

  // One access taken at the next edge; returns with its pins on the bus
  task automatic issue(input logic wr, input logic [31:0] ad, input logic [1:0] sz,
                       input logic pv, input logic [2:0] lsm);
    logic [1:0]  szx;
    logic [31:0] w;
    szx = (sz == 2'h3) ? 2'h2 : sz;
    w = (szx == 2'h0) ? 32'hEFEFEFEF : (szx == 2'h1) ? 32'hCDEFCDEF : 32'h89ABCDEF;
    acc_req = '{addr: ad, wdata: 32'h89ABCDEF, size: sz, write: wr, lock: lsm[2],
                seq: lsm[1], more: lsm[0], priv: pv, mode: {2'h2, lsm}};
    acc_valid = 1'h1;
    @(negedge core_clk);
    acc_valid = 1'h0;
    chk("req_n", data_request_n, 1'h0);
    chk("dir", data_dir_write, wr);
    chk("addr", data_addr_bus, ad);
    chk("size", data_access_size, szx);
    chk("lsm", {data_bus_locked, data_sequential, data_burst_continues}, lsm);
    chk("priv", data_privileged, pv);
    chk("mode", data_cpu_mode, {2'h2, lsm});
    if (wr) chk("wdata", wdata, w);
  endtask : issue

  // Cycle after an access: bus released, read result or fault reported
  task automatic finish_rd(input logic v, input logic f, input logic [31:0] d);
    @(negedge core_clk);
    chk("req_n", data_request_n, 1'h1);
    chk("lock", data_bus_locked, 1'h0);
    chk("valid", load_valid, v);
    chk("fault", access_fault, f);
    if (v) chk("load", load_data, d);
  endtask : finish_rd

  initial begin
    {core_reset_n, wait_state_enable, fiq_mask, irq_mask} = 4'hF;
    {acc_valid, spec_hint, debug_exit, data_watch_halt_in} = 4'h0;
    {fast_int_req_n, normal_int_req_n} = 2'h3;
    spec_addr = 32'h00000000;
    acc_req = '0;
    do_reset(1'h0, 1'h0);
    // Writes of every size with varied qualifiers
    for (int s = 0; s < 3; s++) begin
      issue(1'h1, 32'h00000100 + 32'(4 * s), 2'(s), 1'h1, 3'(3 * s + 1));
      finish_rd(1'h0, 1'h0, 32'h00000000);
    end
    $display("test writes done");
    // Reads of every size code, the reserved one included
    for (int s = 0; s < 4; s++) begin
      a = 32'h00000200 + 32'(s == 0) + 32'(2 * (s == 1));
      issue(1'h0, a, 2'(s), 1'h1, 3'h0);
      finish_rd(1'h1, 1'h0, lane(a, 2'(s), 1'h0));
    end
    // User access to the protected half faults, supervisor does not
    issue(1'h0, 32'h80000010, 2'h2, 1'h0, 3'h0);
    finish_rd(1'h0, 1'h1, 32'h00000000);
    issue(1'h0, 32'h80000010, 2'h2, 1'h1, 3'h0);
    finish_rd(1'h1, 1'h0, lane(32'h80000010, 2'h2, 1'h0));
    $display("test reads done");
    // Speculative probe alone, then together with a real request
    spec_hint = 1'h1;
    spec_addr = 32'h00000040;
    @(negedge core_clk);
    spec_hint = 1'h0;
    chk("spec", {data_speculative_n, data_request_n}, 2'h1);
    chk("addr", data_addr_bus, 32'h00000040);
    @(negedge core_clk);
    chk("fault", access_fault, 1'h1);
    spec_hint = 1'h1;
    issue(1'h0, 32'h00000300, 2'h2, 1'h1, 3'h0);
    spec_hint = 1'h0;
    chk("spec_n", data_speculative_n, 1'h1);
    finish_rd(1'h1, 1'h0, lane(32'h00000300, 2'h2, 1'h0));
    $display("test speculative done");
    // Wait states freeze a locked access on the pins
    issue(1'h1, 32'h00000400, 2'h2, 1'h1, 3'h4);
    wait_state_enable = 1'h0;
    repeat (3) @(negedge core_clk);
    chk("stall", {data_request_n, data_bus_locked}, 2'h1);
    wait_state_enable = 1'h1;
    finish_rd(1'h0, 1'h0, 32'h00000000);
    $display("test wait states done");
    // Each interrupt masked in turn, requests held low
    for (int i = 0; i < 2; i++) begin
      fiq_mask = i[0];
      irq_mask = ~i[0];
      {fast_int_req_n, normal_int_req_n} = 2'h0;
      @(negedge core_clk);
      chk("masked", {fast_int_masked, normal_int_masked}, {i[0], ~i[0]});
      chk("pend", {fast_int_pend, normal_int_pend}, {~i[0], i[0]});
    end
    {fiq_mask, irq_mask} = 2'h0;
    @(negedge core_clk);
    $display("test interrupts done");
    // Watchpoint halts, requests are refused, exit resumes
    issue(1'h0, 32'h00000500, 2'h2, 1'h1, 3'h0);
    data_watch_halt_in = 1'h1;
    @(negedge core_clk);
    data_watch_halt_in = 1'h0;
    chk("halt", {debug_halted, fast_int_masked, normal_int_masked}, 3'h7);
    acc_valid = 1'h1;
    @(negedge core_clk);
    acc_valid = 1'h0;
    chk("req_n", data_request_n, 1'h1);
    debug_exit = 1'h1;
    @(negedge core_clk);
    debug_exit = 1'h0;
    chk("halt", {debug_halted, fast_int_masked, normal_int_masked}, 3'h0);
    $display("test watchpoint done");
    // Async reset mid-access clears the pins at once
    issue(1'h1, 32'h00000600, 2'h2, 1'h1, 3'h7);
    #2 core_reset_n = 1'h0;
    #1 chk("async", {data_request_n, data_bus_locked}, 2'h2);
    @(negedge core_clk);
    core_reset_n = 1'h1;
    // Big-endian straps flip the read lanes
    do_reset(1'h1, 1'h1);
    for (int s = 0; s < 2; s++) begin
      a = 32'h00000701 + 32'(s);
      issue(1'h0, a, 2'(s), 1'h1, 3'h0);
      finish_rd(1'h1, 1'h0, lane(a, 2'(s), 1'h1));
    end
    $display("test byte order done");
    conclude();
  end
endmodule : test_dbs_sideband
